/* src/mosc_ctrl.sv */
// Main oscillator control: AHB-Lite registers, startup countdown, interrupt
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
module mosc_ctrl #(
   parameter int CNT_W = 8,  // Startup count width
   parameter int FREQ_W = 16 // Frequency count width
) (
   input wire logic hclk,                  // System clock, 10 MHz
   input wire logic hresetn,               // Async reset, active low
   input wire logic hsel,                  // Slave select
   input wire logic [31:0] haddr,          // Byte address
   input wire logic [1:0] htrans,          // Transfer type
   input wire logic hwrite,                // Write when high
   input wire logic [2:0] hsize,           // Transfer size, word only
   input wire logic [31:0] hwdata,         // Write data
   input wire logic hready,                // Bus ready
   output logic hreadyout,                 // Slave ready
   output logic hresp,                     // Always OKAY
   output logic [31:0] hrdata,             // Read data
   input wire logic slow_clock,            // Permanent slow clock, sampled
   input wire logic main_clock,            // Main oscillator output, sampled
   input wire logic pll_clock,             // PLL output, sampled
   output logic osc_enable,                // Oscillator power enable
   output logic main_clock_valid,          // Oscillator stable
   output logic master_clock,              // Selected clock
   output mosc_pkg::mosc_clksel_e clk_sel, // Current selection
   output logic irq                        // Level interrupt, active high
);
   import mosc_pkg::*;

   typedef struct packed {
      logic ctrl_en;
      logic [CNT_W-1:0] start_cnt;
      mosc_clksel_e sel;
      logic [EV_W-1:0] mask;
      logic [EV_W-1:0] events;
      mosc_su_e su;
      logic [CNT_W-1:0] su_cnt;
      logic [$clog2(SLOW_DIV)-1:0] div;
      logic slow_prev;
      logic main_prev;
      logic frdy_prev;
      logic ahb_wr;
      logic rd_wait;
      logic [ADDR_W-1:0] ahb_addr;
      logic [31:0] rdata;
      logic mck;
      logic irq;
   } mosc_ctrl_s;

   mosc_ctrl_s q;
   mosc_ctrl_s d;

   mosc_fc_if #(.FREQ_W(FREQ_W)) fc ();

   logic slow_rise;
   logic slow_fall;
   logic main_rise;
   logic div_tick;
   logic accept;
   logic wr_ctrl;
   logic wr_clear;
   logic wr_mask;
   logic [CNT_W-1:0] wr_cnt;
   logic [EV_W-1:0] ev_set;
   logic [31:0] rd_mux;

   // ------------------------------------------------------------------
   // Edge detection
   // ------------------------------------------------------------------
   // Inputs are taken as synchronous; a main clock above half the bus
   // clock cannot be resolved and the measurement then reads low.
   assign slow_rise = slow_clock & ~q.slow_prev;
   assign slow_fall = ~slow_clock & q.slow_prev;
   assign main_rise = main_clock & ~q.main_prev;
   assign div_tick = slow_rise && (q.div == $bits(q.div)'(SLOW_DIV - 1)); // R6

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   assign accept = hsel && htrans[1] && hready;
   assign wr_ctrl = q.ahb_wr && (q.ahb_addr == OFS_OSC_CTRL);
   assign wr_clear = q.ahb_wr && (q.ahb_addr == OFS_IRQ_CLEAR);
   assign wr_mask = q.ahb_wr && (q.ahb_addr == OFS_IRQ_MASK);
   assign wr_cnt = hwdata[CTRL_CNT_LSB +: CNT_W];

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (q.ahb_addr)
         OFS_OSC_CTRL: begin
            rd_mux[CTRL_EN_BIT] = q.ctrl_en;
            rd_mux[CTRL_CNT_LSB +: CNT_W] = q.start_cnt;
            rd_mux[CTRL_SEL_LSB +: 2] = q.sel;
         end
         OFS_MAIN_FREQ: begin
            rd_mux[FREQ_W-1:0] = fc.count; // R11
            rd_mux[FREQ_RDY_BIT] = fc.ready; // R10
         end
         OFS_PWR_STATUS: begin
            rd_mux[EV_STABLE_BIT] = (q.su == SU_STABLE);
            rd_mux[EV_FRDY_BIT] = fc.ready;
         end
         OFS_IRQ_STATUS: rd_mux[EV_W-1:0] = q.events;
         OFS_IRQ_MASK: rd_mux[EV_W-1:0] = q.mask;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      d = q;
      ev_set = '0;
      d.slow_prev = slow_clock;
      d.main_prev = main_clock;
      d.frdy_prev = fc.ready;

      // Bus phases: writes take no wait, reads one wait for registered data
      d.ahb_wr = accept && hwrite;
      d.rd_wait = accept && !hwrite;
      if (accept) begin
         d.ahb_addr = {haddr[ADDR_W-1:2], 2'b00};
      end
      if (q.rd_wait) begin
         d.rdata = rd_mux;
      end

      // Startup countdown on the divided slow clock
      if (slow_rise) begin
         d.div = q.div + 1'b1;
      end
      unique case (q.su)
         SU_OFF: d.su = SU_OFF;
         SU_COUNT: begin
            if (q.su_cnt == '0) begin
               d.su = SU_STABLE; // R8
            end else if (div_tick) begin
               d.su_cnt = q.su_cnt - 1'b1; // R6 R7
            end
         end
         SU_STABLE: d.su = SU_STABLE;
      endcase

      // A control write overrides the countdown in the same cycle
      if (wr_ctrl) begin
         d.ctrl_en = hwdata[CTRL_EN_BIT]; // R3
         d.start_cnt = wr_cnt; // R5
         unique case (hwdata[CTRL_SEL_LSB +: 2])
            2'h1: d.sel = SEL_MAIN;
            2'h2: d.sel = SEL_PLL;
            default: d.sel = SEL_SLOW;
         endcase
         if (hwdata[CTRL_EN_BIT]) begin
            d.su = SU_COUNT; // R6
            d.su_cnt = wr_cnt;
            d.div = '0;
         end else begin
            d.su = SU_OFF; // R4 R12
            d.su_cnt = '0;
         end
      end
      if (wr_mask) begin
         d.mask = hwdata[EV_W-1:0];
      end

      // Sticky events; a new event wins over a clear in the same cycle
      ev_set[EV_STABLE_BIT] = (q.su != SU_STABLE) && (d.su == SU_STABLE); // R8
      ev_set[EV_FRDY_BIT] = fc.ready && !q.frdy_prev;
      d.events = q.events;
      if (wr_clear) begin
         d.events = q.events & ~hwdata[EV_W-1:0];
      end
      d.events = d.events | ev_set;
      d.irq = |(d.events & d.mask); // R8

      // Registered clock selection; main clock only once stable
      unique case (q.sel)
         SEL_SLOW: d.mck = slow_clock; // R1 R2
         SEL_MAIN: d.mck = main_clock && (q.su == SU_STABLE); // R1
         SEL_PLL: d.mck = pll_clock; // R1
         default: d.mck = slow_clock;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) q <= '0; // R2
      else q <= d;
   end

   // ------------------------------------------------------------------
   // Frequency counter
   // ------------------------------------------------------------------
   assign fc.stable = (q.su == SU_STABLE); // R9
   assign fc.slow_rise = slow_rise;
   assign fc.slow_fall = slow_fall;
   assign fc.main_rise = main_rise;

   mosc_freq_cnt #(.FREQ_W(FREQ_W)) u_freq_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .fc(fc.cnt)
   );

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign hreadyout = ~q.rd_wait;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign osc_enable = q.ctrl_en;
   assign main_clock_valid = (q.su == SU_STABLE);
   assign master_clock = q.mck;
   assign clk_sel = q.sel;
   assign irq = q.irq;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_disable_drops_stable: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && !hwdata[CTRL_EN_BIT]) |=> (!main_clock_valid && !osc_enable))
      else $error("stable survived disable"); // R4 R12
   a_enable_restarts: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && hwdata[CTRL_EN_BIT]) |=> (!main_clock_valid && q.su_cnt == $past(wr_cnt)))
      else $error("enable write did not restart countdown"); // R6
   a_tick_decrements: assert property (@(posedge hclk) disable iff (!hresetn)
      (q.su == SU_COUNT && div_tick && q.su_cnt != '0 && !wr_ctrl)
      |=> (q.su_cnt == $past(q.su_cnt) - 1'b1)) else $error("countdown step wrong"); // R6 R7
   a_hold_between_ticks: assert property (@(posedge hclk) disable iff (!hresetn)
      (q.su == SU_COUNT && !div_tick && !wr_ctrl) |=> $stable(q.su_cnt))
      else $error("countdown moved without tick"); // R6
   a_zero_sets_stable: assert property (@(posedge hclk) disable iff (!hresetn)
      (q.su == SU_COUNT && q.su_cnt == '0 && !wr_ctrl)
      |=> (main_clock_valid && q.events[EV_STABLE_BIT])) else $error("zero not stable"); // R8
   a_off_not_stable: assert property (@(posedge hclk) disable iff (!hresetn)
      !osc_enable |-> !main_clock_valid) else $error("stable while disabled"); // R2 R4
   a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
      irq == |(q.events & q.mask)) else $error("irq does not follow status"); // R8
   a_read_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      (accept && !hwrite) |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
endmodule : mosc_ctrl

/* src/mosc_fc_if.sv */
// Link between the control logic and the frequency counter
`timescale 1ns/100ps
interface mosc_fc_if #(parameter int FREQ_W = 16);
   logic stable;
   logic slow_rise;
   logic slow_fall;
   logic main_rise;
   logic [FREQ_W-1:0] count;
   logic ready;
   modport ctl (output stable, output slow_rise, output slow_fall, output main_rise,
                input count, input ready);
   modport cnt (input stable, input slow_rise, input slow_fall, input main_rise,
                output count, output ready);
endinterface : mosc_fc_if

/* src/mosc_freq_cnt.sv */
// Main clock frequency counter gated by slow clock edges
`timescale 1ns/100ps
module mosc_freq_cnt #(
   parameter int FREQ_W = 16
) (
   input wire logic hclk,   // System clock
   input wire logic hresetn, // Async reset, active low
   mosc_fc_if.cnt fc        // Edges in, count out
);
   import mosc_pkg::*;

   typedef struct packed {
      mosc_fc_e st;
      logic [4:0] falls;
      logic [FREQ_W-1:0] count;
      logic ready;
   } mosc_fc_s;

   mosc_fc_s q;
   mosc_fc_s d;

   // ------------------------------------------------------------------
   // Measurement sequence
   // ------------------------------------------------------------------
   always_comb begin
      d = q;
      if (!fc.stable) begin
         // Losing the oscillator invalidates any result
         d = '0;
      end else begin
         unique case (q.st)
            FC_IDLE: d.st = FC_WAIT;
            FC_WAIT: if (fc.slow_rise) d.st = FC_RUN; // R9
            FC_RUN: begin
               // Saturates rather than wraps on a too fast main clock
               if (fc.main_rise && q.count != {FREQ_W{1'b1}}) begin
                  d.count = q.count + 1'b1; // R11
               end
               if (fc.slow_fall) begin
                  d.falls = q.falls + 5'h01;
                  if (q.falls == 5'(MEAS_FALL_EDGES - 1)) begin
                     d.st = FC_DONE; // R10
                     d.ready = 1'b1;
                  end
               end
            end
            FC_DONE: d.st = FC_DONE;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) q <= '0;
      else q <= d;
   end

   assign fc.count = q.count;
   assign fc.ready = q.ready;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_ready_needs_stable: assert property (@(posedge hclk) disable iff (!hresetn)
      !fc.stable |=> !fc.ready) else $error("ready without stable oscillator"); // R10
   a_ready_on_last_fall: assert property (@(posedge hclk) disable iff (!hresetn)
      (q.st == FC_RUN && fc.slow_fall && q.falls == 5'hF && fc.stable)
      |=> (fc.ready || !fc.stable)) else $error("ready not set at last fall"); // R10
   a_count_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
      (fc.ready && fc.stable) |=> (!fc.stable || $stable(fc.count)))
      else $error("count moved after ready"); // R10
   a_no_count_early: assert property (@(posedge hclk) disable iff (!hresetn)
      (q.st == FC_IDLE || q.st == FC_WAIT) |-> (q.count == '0))
      else $error("count before slow rise"); // R9
   a_count_step: assert property (@(posedge hclk) disable iff (!hresetn)
      (q.st == FC_RUN && fc.stable && fc.main_rise && q.count == '0)
      |=> (!fc.stable || q.count == FREQ_W'(1))) else $error("main edge not counted"); // R11
endmodule : mosc_freq_cnt

/* src/mosc_pkg.sv */
// Constants and types for the main oscillator startup and frequency counter
//
// Functional notes
// R1: Three clocks are offered: permanent slow clock, main oscillator clock, PLL clock.
// R2: After reset the oscillator is off and the slow clock is selected.
// R3: Software switches the oscillator on or off through the enable bit.
// R4: Clearing the enable bit clears the stable flag at once.
// R5: Software loads a startup count covering the crystal startup time.
// R6: Enable write with count clears stable and counts down on slow clock over 8.
// R7: The startup count is 8 bits, so startup is at most about 62 ms.
// R8: Count reaching zero sets the stable flag, which can raise an interrupt.
// R9: Once stable, counting of main clocks starts after next slow rising edge.
// R10: At the 16th slow falling edge counting stops and ready is set.
// R11: The frequency value is main clock cycles in 16 slow clock periods.
// R12: Disabling abandons a countdown; stable stays low until a full new countdown.
package mosc_pkg;
   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_OSC_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MAIN_FREQ = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_PWR_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CNT_LSB = 8;
   localparam int CTRL_SEL_LSB = 16;
   localparam int FREQ_RDY_BIT = 16;
   localparam int EV_STABLE_BIT = 0;
   localparam int EV_FRDY_BIT = 1;
   localparam int EV_W = 2;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int STARTUP_CNT_W = 8;
   localparam int STARTUP_MAX_MS = 62;
   localparam int SLOW_DIV = 8;
   localparam int MEAS_FALL_EDGES = 16;
   localparam int FREQ_CNT_W = 16;
   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {SEL_SLOW, SEL_MAIN, SEL_PLL} mosc_clksel_e;
   typedef enum logic [1:0] {SU_OFF, SU_COUNT, SU_STABLE} mosc_su_e;
   typedef enum logic [1:0] {FC_IDLE, FC_WAIT, FC_RUN, FC_DONE} mosc_fc_e;
endpackage : mosc_pkg

/* testbench/mosc_osc_model.sv */
// Behavioural model of the crystal oscillator and the other clock sources
`timescale 1ns/100ps
module mosc_osc_model #(
   parameter int SLOW_HALF = 8, // Slow clock half period in hclk cycles
   parameter int MAIN_HALF = 2, // Main clock half period in hclk cycles
   parameter int PLL_HALF = 3   // PLL clock half period in hclk cycles
) (
   input wire logic hclk,       // Timing reference of the model
   input wire logic osc_enable, // Oscillator power enable
   output logic slow_clock,     // Permanent slow clock
   output logic main_clock,     // Crystal output, still while powered off
   output logic pll_clock       // PLL output
);
   int slow_cnt = 0;
   int main_cnt = 0;
   int pll_cnt = 0;

   initial begin
      slow_clock = 1'b0;
      main_clock = 1'b0;
      pll_clock = 1'b0;
   end

   // ------------------------------------------------------------------
   // Clock sources
   // ------------------------------------------------------------------
   always @(posedge hclk) begin
      // Slow clock never stops
      slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
      if (slow_cnt == SLOW_HALF - 1) begin
         slow_clock <= ~slow_clock;
      end
      pll_cnt <= (pll_cnt == PLL_HALF - 1) ? 0 : pll_cnt + 1;
      if (pll_cnt == PLL_HALF - 1) begin
         pll_clock <= ~pll_clock;
      end
      // A powered-down crystal gives no edges at all
      if (!osc_enable) begin
         main_cnt <= 0;
         main_clock <= 1'b0;
      end else begin
         main_cnt <= (main_cnt == MAIN_HALF - 1) ? 0 : main_cnt + 1;
         if (main_cnt == MAIN_HALF - 1) begin
            main_clock <= ~main_clock;
         end
      end
   end
endmodule : mosc_osc_model

/* testbench/testbench.sv */
// Self-checking testbench for the main oscillator control block
`timescale 1ns/100ps
module testbench;
   import mosc_pkg::*;
   localparam int SLOW_HALF = 8;
   localparam int MAIN_HALF = 2;
   localparam int EXP_FREQ = MEAS_FALL_EDGES * SLOW_HALF / MAIN_HALF;
   localparam int EXP_SU = 2 * SLOW_DIV * 2 * SLOW_HALF;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, osc_enable, main_clock_valid, master_clock, irq;
   logic slow_clock, main_clock, pll_clock;
   logic slow_d, pll_d, main_d, mck_exp;
   logic [31:0] hrdata, rd;
   mosc_clksel_e clk_sel;
   mosc_clksel_e sel_exp [4] = '{SEL_SLOW, SEL_MAIN, SEL_PLL, SEL_SLOW};
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   int n;

   always #50 hclk = ~hclk;

   // Source levels as the design saw them at the last rising edge
   always @(posedge hclk) begin
      slow_d <= slow_clock;
      pll_d <= pll_clock;
      main_d <= main_clock;
   end

   mosc_ctrl #(.CNT_W(STARTUP_CNT_W), .FREQ_W(FREQ_CNT_W)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .slow_clock(slow_clock),
      .main_clock(main_clock), .pll_clock(pll_clock), .osc_enable(osc_enable),
      .main_clock_valid(main_clock_valid), .master_clock(master_clock),
      .clk_sel(clk_sel), .irq(irq));

   mosc_osc_model #(.SLOW_HALF(SLOW_HALF), .MAIN_HALF(MAIN_HALF), .PLL_HALF(3)) u_osc (
      .hclk(hclk), .osc_enable(osc_enable), .slow_clock(slow_clock),
      .main_clock(main_clock), .pll_clock(pll_clock));

   // ------------------------------------------------------------------
   // Reporting
   // ------------------------------------------------------------------
   task stop_test;
      if (fails == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Whole run needs about 900 cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         stop_test();
      end
   end

   // ------------------------------------------------------------------
   // Bus access
   // ------------------------------------------------------------------
   // Each phase is held until ready is seen high at a rising edge
   task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
            output logic [31:0] rdat);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, addr};
      hwrite <= wr;
      htrans <= 2'h2;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : bus

   task wr32(input logic [7:0] addr, input logic [31:0] data);
      bus(1'b1, addr, data, rd);
   endtask : wr32

   task rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      bus(1'b0, addr, 32'h0, rd);
      check(rd, exp);
   endtask : rd_chk

   // Bounded wait for stable (0) or interrupt (1)
   task wait_hi(input logic use_irq, output int cnt);
      cnt = 0;
      do begin
         @(negedge hclk);
         cnt++;
      end while (((use_irq ? irq : main_clock_valid) !== 1'b1) && cnt < 600);
   endtask : wait_hi

   task settle;
      repeat (3) @(negedge hclk);
   endtask : settle

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      check({26'h0, hresp, osc_enable, main_clock_valid, irq, clk_sel}, 32'h0);
      rd_chk(OFS_OSC_CTRL, 32'h0);
      rd_chk(OFS_PWR_STATUS, 32'h0);
      wr32(8'h18, 32'hFFFF_FFFF);
      rd_chk(8'h18, 32'h0);
      wr32(OFS_PWR_STATUS, 32'hFFFF_FFFF);
      rd_chk(OFS_PWR_STATUS, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr32(OFS_OSC_CTRL, i << CTRL_SEL_LSB);
         settle();
         check({30'h0, clk_sel}, {30'h0, sel_exp[i]});
         repeat (8) begin
            @(negedge hclk);
            mck_exp = (i == 1) ? 1'b0 : ((i == 2) ? pll_d : slow_d);
            check({31'h0, master_clock}, {31'h0, mck_exp});
         end
      end
      // Count of zero: stable almost at once, event masked off
      wr32(OFS_IRQ_MASK, 32'h0);
      wr32(OFS_OSC_CTRL, 32'h0000_0001);
      wait_hi(1'b0, n);
      check({31'h0, n <= 3}, 32'h1);
      check({30'h0, osc_enable, irq}, 32'h2);
      rd_chk(OFS_IRQ_STATUS, 32'h1);
      wr32(OFS_IRQ_MASK, 32'h2);
      rd_chk(OFS_IRQ_MASK, 32'h2);
      wait_hi(1'b1, n);
      bus(1'b0, OFS_MAIN_FREQ, 32'h0, rd);
      check({31'h0, rd[FREQ_RDY_BIT]}, 32'h1);
      check({31'h0, rd[15:0] >= EXP_FREQ - 4 && rd[15:0] <= EXP_FREQ + 2}, 32'h1);
      check({31'h0, n >= EXP_FREQ * MAIN_HALF * 2 - 2 * SLOW_HALF}, 32'h1);
      rd_chk(OFS_PWR_STATUS, 32'h3);
      rd_chk(OFS_IRQ_STATUS, 32'h3);
      wr32(OFS_IRQ_CLEAR, 32'h2);
      settle();
      check({31'h0, irq}, 32'h0);
      wr32(OFS_IRQ_MASK, 32'h1);
      settle();
      check({31'h0, irq}, 32'h1);
      wr32(OFS_IRQ_CLEAR, 32'h1);
      settle();
      check({31'h0, irq}, 32'h0);
      rd_chk(OFS_IRQ_STATUS, 32'h0);
      // Switching off drops stable and the measurement
      wr32(OFS_OSC_CTRL, 32'h0);
      settle();
      check({30'h0, osc_enable, main_clock_valid}, 32'h0);
      rd_chk(OFS_PWR_STATUS, 32'h0);
      rd_chk(OFS_MAIN_FREQ, 32'h0);
      // Countdown abandoned three quarters through, then a full new one
      wr32(OFS_OSC_CTRL, 32'h0000_0201);
      repeat (EXP_SU * 3 / 4) @(negedge hclk);
      check({31'h0, main_clock_valid}, 32'h0);
      wr32(OFS_OSC_CTRL, 32'h0);
      wr32(OFS_OSC_CTRL, 32'h0001_0201);
      wait_hi(1'b0, n);
      check({31'h0, n >= EXP_SU - 2 * SLOW_HALF}, 32'h1);
      check({31'h0, n <= EXP_SU + 2 * SLOW_HALF + 4}, 32'h1);
      repeat (8) begin
         @(negedge hclk);
         check({31'h0, master_clock}, {31'h0, main_d});
      end
      rd_chk(OFS_OSC_CTRL, 32'h0001_0201);
      // Widest count: a new enable write clears stable again
      wr32(OFS_OSC_CTRL, 32'h0000_FF01);
      rd_chk(OFS_OSC_CTRL, 32'h0000_FF01);
      check({31'h0, main_clock_valid}, 32'h0);
      stop_test();
   end
endmodule : testbench
